// *** rtl/tmc_pkg.sv ***
// Package for the two-unit 8-bit timer mode control block.
// Assumes a single 20 MHz peripheral clock and a byte-wide register port.
package tmc_pkg;
	// Register offsets
	localparam logic [15:0] ADDR_MODE_U0 = 16'hFF69;
	localparam logic [15:0] ADDR_MODE_U1 = 16'hFF6C;
	localparam logic [15:0] ADDR_COMP0_U0 = 16'hFF80;
	localparam logic [15:0] ADDR_COMP1_U0 = 16'hFF81;
	localparam logic [15:0] ADDR_COMP0_U1 = 16'hFF82;
	localparam logic [15:0] ADDR_COMP1_U1 = 16'hFF83;
	localparam logic [15:0] ADDR_IRQ_STAT = 16'hFF84;
	localparam logic [15:0] ADDR_IRQ_MASK = 16'hFF85;
	localparam logic [15:0] ADDR_PORT = 16'hFF86;
	localparam logic [15:0] ADDR_COUNT_U0 = 16'hFF87;
	localparam logic [15:0] ADDR_COUNT_U1 = 16'hFF88;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [3:0] PORT_RST = 4'h3;
	// Mode register field positions
	localparam int RUN_BIT = 7;
	localparam int CKS_HI = 6;
	localparam int CKS_LO = 4;
	localparam int MD_HI = 3;
	localparam int MD_LO = 2;
	localparam int LEV_BIT = 1;
	localparam int OEN_BIT = 0;
	// Port register field positions: dir0, latch0, dir1, latch1
	localparam int PDIR0 = 0;
	localparam int PLAT0 = 1;
	localparam int PDIR1 = 2;
	localparam int PLAT1 = 3;
	// Operating mode codes
	localparam logic [1:0] MD_INTERVAL = 2'h0;
	localparam logic [1:0] MD_CARRIER = 2'h1;
	localparam logic [1:0] MD_PWM = 2'h2;
	// Prescaler tap positions (divide by 2^k means bit k-1 falls from one to zero)
	localparam int PRE_W = 12;
	localparam logic [7:0] CNT_ONE = 8'h01;
endpackage

// *** rtl/tmc_unit.sv ***
// One 8-bit timer unit: counter, compare logic and wave output.
// Assumes a one-cycle count tick from the parent and registered mode bits.
`timescale 1ns/1ps
module tmc_unit (
	input wire logic clk_i, // Peripheral clock
	input wire logic rst_n_i, // Synchronised reset, active low
	input wire logic [7:0] mode_i, // Mode register
	input wire logic tick_i, // Count clock pulse
	input wire logic [7:0] comp0_i, // First compare value
	input wire logic [7:0] comp1_i, // Second compare value
	output logic [7:0] count_o, // Counter value
	output logic match_o, // Interrupt event pulse
	output logic wave_o // Timer wave output
);
	typedef struct packed {
		logic [7:0] cnt;
		logic match;
		logic wave;
		logic phase; // High while comparing against the second register
	} tmc_unit_st_t;
	tmc_unit_st_t s_r, s_nxt;
	logic run, lev, oen;
	logic [1:0] md;
	assign run = mode_i[tmc_pkg::RUN_BIT];
	assign md = mode_i[tmc_pkg::MD_HI:tmc_pkg::MD_LO];
	assign lev = mode_i[tmc_pkg::LEV_BIT];
	assign oen = mode_i[tmc_pkg::OEN_BIT];

	// Counter and wave sequencing
	always_comb begin
		s_nxt = s_r;
		s_nxt.match = 1'b0;
		if (!run || !oen) begin
			s_nxt.cnt = tmc_pkg::ZERO8;
			s_nxt.phase = 1'b0;
			// idle level when stopped or disabled
			s_nxt.wave = lev;
			if (run) begin
				s_nxt.cnt = s_r.cnt;
			end
		end
		if (run && tick_i) begin
			s_nxt.cnt = s_r.cnt + tmc_pkg::CNT_ONE;
			if (md == tmc_pkg::MD_CARRIER && s_r.cnt == comp1_i) begin
				s_nxt.cnt = tmc_pkg::ZERO8;
				s_nxt.match = 1'b1;
			end else if (!s_r.phase && s_r.cnt == comp0_i) begin
				s_nxt.cnt = tmc_pkg::ZERO8;
				s_nxt.match = 1'b1;
				s_nxt.wave = oen ? ~s_r.wave : lev;
				if (md == tmc_pkg::MD_PWM) begin
					s_nxt.phase = 1'b1;
				end
			end else if (s_r.phase && s_r.cnt == comp1_i) begin
				s_nxt.wave = oen ? ~s_r.wave : lev;
				s_nxt.phase = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count_o = s_r.cnt;
	assign match_o = s_r.match;
	assign wave_o = s_r.wave;

	a_stop_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!run |=> s_r.cnt == tmc_pkg::ZERO8) else $error("counter not cleared on stop");
	a_match_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run && tick_i && !s_r.phase && md != tmc_pkg::MD_CARRIER && s_r.cnt == comp0_i
		|=> match_o && count_o == tmc_pkg::ZERO8) else $error("missing match");
	a_idle_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!run ##1 !run |-> wave_o == $past(lev)) else $error("idle level wrong");
	// carrier mode clears the count on the second compare
	a_carrier_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		run && tick_i && md == tmc_pkg::MD_CARRIER && s_r.cnt == comp1_i
		|=> match_o && count_o == tmc_pkg::ZERO8) else $error("carrier clear missing");
	c_match_seen: cover property (@(posedge clk_i) disable iff (!rst_n_i) match_o);
endmodule // tmc_unit

// *** rtl/tmc_top.sv ***
// Mode control for two 8-bit timer units with register port and interrupt.
// Assumes a byte register port with read data one cycle after the strobe.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module tmc_top (
	input wire logic core_clk_i, // 20 MHz peripheral clock
	input wire logic nrst_i, // Asynchronous reset, active low
	input wire logic [15:0] addr_i, // Register address
	input wire logic [7:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	input wire logic partner_tick_i, // Partner timer output pulse
	input wire logic low_speed_osc_i, // Low-speed oscillator tick pulse
	output logic [7:0] rdata_o, // Read data, one cycle after strobe
	output logic compare_irq_o, // Level interrupt
	output logic wave_out_u0_o, // Pin level unit 0
	output logic wave_out_u0_oe_o, // Pin drive enable unit 0
	output logic wave_out_u1_o, // Pin level unit 1
	output logic wave_out_u1_oe_o // Pin drive enable unit 1
);
	typedef struct packed {
		logic [7:0] mode0;
		logic [7:0] mode1;
		logic [7:0] cmp00;
		logic [7:0] duty_compare_u0;
		logic [7:0] cmp01;
		logic [7:0] duty_compare_u1;
		logic [1:0] stat;
		logic [1:0] mask;
		logic [3:0] port;
		logic [tmc_pkg::PRE_W-1:0] pre;
		logic [8:0] lso;
		logic [7:0] rdata;
		logic irq;
		logic p0;
		logic oe0;
		logic p1;
		logic oe1;
	} tmc_st_t;
	tmc_st_t s_r, s_nxt;
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic tick0, tick1, m0, m1, w0, w1;
	logic [7:0] cnt0, cnt1;
	logic [tmc_pkg::PRE_W-1:0] pre_inc;
	logic [8:0] lso_inc;

	// Reset release through two flops
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// Pulse when the prescaler carries into bit k (divide by 2^k); k=0 is every cycle
	function automatic logic div_tick(input logic [tmc_pkg::PRE_W-1:0] cur,
		input logic [tmc_pkg::PRE_W-1:0] nxt, input int k);
		if (k == 0) begin
			div_tick = 1'b1;
		end else begin
			div_tick = (cur[k-1] && !nxt[k-1]);
		end
	endfunction

	assign pre_inc = s_r.pre + {{(tmc_pkg::PRE_W-1){1'b0}}, 1'b1};
	assign lso_inc = s_r.lso + 9'h001;

	always_comb begin
		case (s_r.mode0[tmc_pkg::CKS_HI:tmc_pkg::CKS_LO])
			3'h0: tick0 = div_tick(s_r.pre, pre_inc, 0);
			3'h1: tick0 = div_tick(s_r.pre, pre_inc, 1);
			3'h2: tick0 = div_tick(s_r.pre, pre_inc, 2);
			3'h3: tick0 = div_tick(s_r.pre, pre_inc, 6);
			3'h4: tick0 = div_tick(s_r.pre, pre_inc, 10);
			3'h5: tick0 = partner_tick_i;
			default: tick0 = 1'b0; // Prohibited codes never count
		endcase
	end

	always_comb begin
		case (s_r.mode1[tmc_pkg::CKS_HI:tmc_pkg::CKS_LO])
			3'h0: tick1 = div_tick(s_r.pre, pre_inc, 0);
			3'h1: tick1 = div_tick(s_r.pre, pre_inc, 2);
			3'h2: tick1 = div_tick(s_r.pre, pre_inc, 4);
			3'h3: tick1 = div_tick(s_r.pre, pre_inc, 6);
			3'h4: tick1 = div_tick(s_r.pre, pre_inc, 12);
			3'h5: tick1 = low_speed_osc_i && s_r.lso[6:0] == 7'h7F;
			3'h6: tick1 = low_speed_osc_i && s_r.lso == 9'h1FF;
			default: tick1 = low_speed_osc_i;
		endcase
	end

	tmc_unit u_unit0 (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.mode_i(s_r.mode0),
		.tick_i(tick0),
		.comp0_i(s_r.cmp00),
		.comp1_i(s_r.duty_compare_u0),
		.count_o(cnt0),
		.match_o(m0),
		.wave_o(w0)
	);

	tmc_unit u_unit1 (
		.clk_i(core_clk_i),
		.rst_n_i(rst_n),
		.mode_i(s_r.mode1),
		.tick_i(tick1),
		.comp0_i(s_r.cmp01),
		.comp1_i(s_r.duty_compare_u1),
		.count_o(cnt1),
		.match_o(m1),
		.wave_o(w1)
	);

	// Register port, interrupt status and pin drive
	always_comb begin
		s_nxt = s_r;
		s_nxt.pre = pre_inc;
		s_nxt.lso = low_speed_osc_i ? lso_inc : s_r.lso;
		s_nxt.rdata = tmc_pkg::ZERO8;
		// capture writes in this clock domain
		if (wr_i) begin
			case (addr_i)
				tmc_pkg::ADDR_MODE_U0: begin
					// prohibited unit 0 mode codes fall back to interval
					s_nxt.mode0 = wdata_i;
					if (wdata_i[tmc_pkg::MD_LO]) begin
						s_nxt.mode0[tmc_pkg::MD_HI:tmc_pkg::MD_LO] = tmc_pkg::MD_INTERVAL;
					end
				end
				tmc_pkg::ADDR_MODE_U1: begin
					// unit 1 code 11 is prohibited
					s_nxt.mode1 = wdata_i;
					if (wdata_i[tmc_pkg::MD_HI:tmc_pkg::MD_LO] == 2'h3) begin
						s_nxt.mode1[tmc_pkg::MD_HI:tmc_pkg::MD_LO] = tmc_pkg::MD_INTERVAL;
					end
				end
				tmc_pkg::ADDR_COMP0_U0: s_nxt.cmp00 = wdata_i;
				tmc_pkg::ADDR_COMP1_U0: s_nxt.duty_compare_u0 = wdata_i;
				tmc_pkg::ADDR_COMP0_U1: s_nxt.cmp01 = wdata_i;
				tmc_pkg::ADDR_COMP1_U1: s_nxt.duty_compare_u1 = wdata_i;
				tmc_pkg::ADDR_IRQ_STAT: s_nxt.stat = s_r.stat & ~wdata_i[1:0];
				tmc_pkg::ADDR_IRQ_MASK: s_nxt.mask = wdata_i[1:0];
				tmc_pkg::ADDR_PORT: s_nxt.port = wdata_i[3:0];
				default: ;
			endcase
		end
		// Set wins over a clear in the same cycle
		s_nxt.stat = s_nxt.stat | {m1, m0};
		if (rd_i) begin
			case (addr_i)
				tmc_pkg::ADDR_MODE_U0: s_nxt.rdata = s_r.mode0;
				tmc_pkg::ADDR_MODE_U1: s_nxt.rdata = s_r.mode1;
				tmc_pkg::ADDR_COMP0_U0: s_nxt.rdata = s_r.cmp00;
				tmc_pkg::ADDR_COMP1_U0: s_nxt.rdata = s_r.duty_compare_u0;
				tmc_pkg::ADDR_COMP0_U1: s_nxt.rdata = s_r.cmp01;
				tmc_pkg::ADDR_COMP1_U1: s_nxt.rdata = s_r.duty_compare_u1;
				tmc_pkg::ADDR_IRQ_STAT: s_nxt.rdata = {6'h00, s_r.stat};
				tmc_pkg::ADDR_IRQ_MASK: s_nxt.rdata = {6'h00, s_r.mask};
				tmc_pkg::ADDR_PORT: s_nxt.rdata = {4'h0, s_r.port};
				tmc_pkg::ADDR_COUNT_U0: s_nxt.rdata = cnt0;
				tmc_pkg::ADDR_COUNT_U1: s_nxt.rdata = cnt1;
				default: s_nxt.rdata = tmc_pkg::ZERO8; // Unmapped reads zero
			endcase
		end
		s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
		// disabled output shows the idle level; pin needs dir 0 and latch 0
		s_nxt.oe0 = !s_r.port[tmc_pkg::PDIR0];
		s_nxt.p0 = (s_r.mode0[tmc_pkg::OEN_BIT] ? w0 : s_r.mode0[tmc_pkg::LEV_BIT])
			| s_r.port[tmc_pkg::PLAT0];
		s_nxt.oe1 = !s_r.port[tmc_pkg::PDIR1];
		s_nxt.p1 = (s_r.mode1[tmc_pkg::OEN_BIT] ? w1 : s_r.mode1[tmc_pkg::LEV_BIT])
			| s_r.port[tmc_pkg::PLAT1];
	end

	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.port <= tmc_pkg::PORT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_o = s_r.rdata;
	assign compare_irq_o = s_r.irq;
	assign wave_out_u0_o = s_r.p0;
	assign wave_out_u0_oe_o = s_r.oe0;
	assign wave_out_u1_o = s_r.p1;
	assign wave_out_u1_oe_o = s_r.oe1;

	a_mode_readback: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		rd_i && !wr_i && addr_i == tmc_pkg::ADDR_MODE_U0 |=> rdata_o == $past(s_r.mode0))
		else $error("mode readback wrong");
	a_mode_write: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		wr_i && addr_i == tmc_pkg::ADDR_MODE_U1 && wdata_i[3:2] != 2'h3
		|=> s_r.mode1 == $past(wdata_i)) else $error("mode write lost");
	a_reset_zero: assert property (@(posedge core_clk_i)
		$rose(rst_n) |-> s_r.mode0 == tmc_pkg::MODE_RST && s_r.mode1 == tmc_pkg::MODE_RST)
		else $error("mode not reset");
	a_stat_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		m0 |=> s_r.stat[0]) else $error("status not set");
	// prohibited unit 1 code never stored
	a_mode_legal: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		s_r.mode1[3:2] != 2'h3) else $error("prohibited mode stored");
	// divide by one ticks every cycle
	a_div_one: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		s_r.mode0[6:4] == 3'h0 |-> tick0) else $error("div1 tick missing");
	// prohibited-free osc select uses osc pulse
	a_osc_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		s_r.mode1[6:4] == 3'h7 |-> tick1 == low_speed_osc_i) else $error("osc select");
	a_pin_latch: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		s_r.port[tmc_pkg::PLAT0] ##1 s_r.port[tmc_pkg::PLAT0] |-> wave_out_u0_o)
		else $error("latch ignored");
	a_out_off: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!s_r.mode1[0] && !s_r.port[3] |=> wave_out_u1_o == $past(s_r.mode1[1]))
		else $error("disabled output not idle");
	a_irq_level: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		compare_irq_o == |(s_r.stat & s_r.mask)) else $error("irq level wrong");
	// a one written clears status when no new event arrives
	a_stat_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		wr_i && addr_i == tmc_pkg::ADDR_IRQ_STAT && wdata_i[1] && !m1 |=> !s_r.stat[1])
		else $error("status not cleared");
	// read data stand only after a read strobe
	a_rdata_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!rd_i |=> rdata_o == tmc_pkg::ZERO8) else $error("stray read data");
	c_irq_high: cover property (@(posedge core_clk_i) disable iff (!rst_n) compare_irq_o);
	c_pwm_run: cover property (@(posedge core_clk_i) disable iff (!rst_n)
		s_r.mode0[7] && s_r.mode0[3:2] == tmc_pkg::MD_PWM && m0);
	c_carrier: cover property (@(posedge core_clk_i) disable iff (!rst_n)
		s_r.mode1[3:2] == tmc_pkg::MD_CARRIER && m1);
endmodule // tmc_top

// *** tb/eight_bit_timer_mode_control_tb.sv ***
// Self-checking bench for the two-unit timer mode control block.
// Assumes read data stand one cycle after the read strobe and one clock of 20 MHz.
`timescale 1ns/1ps
module eight_bit_timer_mode_control_tb;
	localparam logic [15:0] a_m0 = tmc_pkg::ADDR_MODE_U0;
	localparam logic [15:0] a_m1 = tmc_pkg::ADDR_MODE_U1;
	localparam logic [15:0] a_st = tmc_pkg::ADDR_IRQ_STAT;
	localparam logic [15:0] a_mk = tmc_pkg::ADDR_IRQ_MASK;
	localparam logic [15:0] a_pt = tmc_pkg::ADDR_PORT;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic partner_tick_i = 1'b0;
	logic low_speed_osc_i = 1'b0;
	logic [7:0] rdata_o;
	logic compare_irq_o, wave_out_u0_o, wave_out_u0_oe_o, wave_out_u1_o, wave_out_u1_oe_o;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [1:0] tick_cnt = 2'h0;
	logic [7:0] v1, v2, hi, lo;
	int div_u0 [6] = '{1, 2, 4, 64, 1024, 4};
	int div_u1 [8] = '{1, 4, 16, 64, 4096, 512, 2048, 4};

	tmc_top uut (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.partner_tick_i(partner_tick_i),
		.low_speed_osc_i(low_speed_osc_i),
		.rdata_o(rdata_o),
		.compare_irq_o(compare_irq_o),
		.wave_out_u0_o(wave_out_u0_o),
		.wave_out_u0_oe_o(wave_out_u0_oe_o),
		.wave_out_u1_o(wave_out_u1_o),
		.wave_out_u1_oe_o(wave_out_u1_oe_o)
	);

	// 50 ns period
	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end

	// Both external ticks pulse every fourth cycle, so any window of 4k cycles sees k pulses
	// partner pulses run from the start, before unit 0 ever selects them
	always @(posedge core_clk_i) begin
		tick_cnt <= tick_cnt + 2'h1;
		partner_tick_i <= (tick_cnt == 2'h0);
		low_speed_osc_i <= (tick_cnt == 2'h0);
		cycles <= cycles + 1;
		// The whole run needs about 16000 cycles; the ceiling leaves ample margin
		if (cycles == 40000) begin
			miscompares = miscompares + 1;
			results();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge core_clk_i);
		nrst_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge core_clk_i);
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge core_clk_i);
		wr_i <= 1'b0;
	endtask

	// Read data are taken in the single cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge core_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d, e);
	endtask

	// Pin levels and drive enables once the registered outputs have settled
	task automatic pins(input logic p0, input logic e0, input logic p1, input logic e1);
		repeat (3) @(posedge core_clk_i);
		#1 chk({4'h0, wave_out_u1_oe_o, wave_out_u1_o, wave_out_u0_oe_o, wave_out_u0_o},
			{4'h0, e1, p1, e0, p0});
	endtask

	// Tick rate: counter difference across exactly two divider periods must be two
	task automatic meas(input logic [15:0] ma, input logic [15:0] ca, input logic [2:0] code,
		input int div);
		// stop first, so no other mode bit changes while running
		wr(ma, 8'h00);
		rdchk(ca, 8'h00);
		wr(ma, {1'b1, code, 4'h0});
		repeat (4) @(posedge core_clk_i);
		rd(ca, v1);
		repeat (2 * div - 2) @(posedge core_clk_i);
		rd(ca, v2);
		chk(8'(v2 - v1), 8'h02);
	endtask

	// Records which levels each pin showed over 24 cycles
	task automatic watch(output logic [7:0] h, output logic [7:0] l);
		h = 8'h00;
		l = 8'h00;
		repeat (24) begin
			@(posedge core_clk_i);
			#1 h = h | {6'h00, wave_out_u1_o, wave_out_u0_o};
			l = l | {6'h00, ~wave_out_u1_o, ~wave_out_u0_o};
		end
	endtask

	// Main sequence
	initial begin
		do_reset();
		rdchk(a_m0, tmc_pkg::MODE_RST);
		rdchk(a_m1, tmc_pkg::MODE_RST);
		rdchk(16'hFF00, 8'h00);
		rdchk(a_st, 8'h00);
		pins(1'b1, 1'b0, 1'b0, 1'b1);
		wr(a_m0, 8'h4A);
		rdchk(a_m0, 8'h4A);
		wr(a_m1, 8'h76);
		rdchk(a_m1, 8'h76);
		wr(a_m0, 8'h04);
		rdchk(a_m0, 8'h00);
		wr(a_m1, 8'h0C);
		rdchk(a_m1, 8'h00);
		wr(a_m1, 8'h08);
		rdchk(a_m1, 8'h08);
		wr(tmc_pkg::ADDR_COUNT_U0, 8'h55);
		rdchk(tmc_pkg::ADDR_COUNT_U0, 8'h00);
		// Idle level, latch and direction all shape the pins
		wr(a_pt, 8'h00);
		wr(a_m0, 8'h02);
		wr(a_m1, 8'h02);
		pins(1'b1, 1'b1, 1'b1, 1'b1);
		wr(a_m0, 8'h00);
		wr(a_m1, 8'h00);
		pins(1'b0, 1'b1, 1'b0, 1'b1);
		wr(a_pt, 8'h0A);
		pins(1'b1, 1'b1, 1'b1, 1'b1);
		wr(a_pt, 8'h05);
		pins(1'b0, 1'b0, 1'b0, 1'b0);
		wr(a_pt, 8'h00);
		// Compare at the top so the interval clear stays out of the way
		wr(tmc_pkg::ADDR_COMP0_U0, 8'hFF);
		wr(tmc_pkg::ADDR_COMP0_U1, 8'hFF);
		for (int i = 0; i < 6; i++) begin
			meas(a_m0, tmc_pkg::ADDR_COUNT_U0, 3'(i), div_u0[i]);
		end
		for (int i = 0; i < 8; i++) begin
			meas(a_m1, tmc_pkg::ADDR_COUNT_U1, 3'(i), div_u1[i]);
		end
		wr(a_m0, 8'h00);
		wr(a_m1, 8'h00);
		// Short intervals: unit 0 drives its wave, unit 1 keeps the idle level
		wr(tmc_pkg::ADDR_COMP0_U0, 8'h03);
		wr(tmc_pkg::ADDR_COMP0_U1, 8'h02);
		wr(a_mk, 8'h01);
		wr(a_m0, 8'h81);
		wr(a_m1, 8'h80);
		watch(hi, lo);
		chk(hi, 8'h01);
		chk(lo, 8'h03);
		rdchk(a_st, 8'h03);
		chk(8'(compare_irq_o), 8'h01);
		wr(a_mk, 8'h00);
		repeat (2) @(posedge core_clk_i);
		#1 chk(8'(compare_irq_o), 8'h00);
		wr(a_m0, 8'h01);
		wr(a_m1, 8'h00);
		wr(a_st, 8'h01);
		rdchk(a_st, 8'h02);
		wr(a_st, 8'h02);
		rdchk(a_st, 8'h00);
		wr(a_mk, 8'h03);
		repeat (2) @(posedge core_clk_i);
		#1 chk(8'(compare_irq_o), 8'h00);
		// Carrier mode on unit 1: count clears on the second compare
		wr(tmc_pkg::ADDR_COMP1_U1, 8'h02);
		wr(a_m1, 8'h84);
		repeat (8) @(posedge core_clk_i);
		rdchk(a_st, 8'h02);
		chk(8'(compare_irq_o), 8'h01);
		wr(a_m1, 8'h04);
		wr(a_st, 8'h02);
		// PWM on unit 0: both compares toggle the wave
		wr(tmc_pkg::ADDR_COMP1_U0, 8'h01);
		rdchk(tmc_pkg::ADDR_COMP1_U0, 8'h01);
		wr(a_m0, 8'h89);
		watch(hi, lo);
		chk(hi, 8'h01);
		chk(lo, 8'h03);
		wr(a_m0, 8'h09);
		rdchk(a_st, 8'h01);
		wr(a_st, 8'h01);
		// Second reset while a unit is counting
		wr(a_m0, 8'hC0);
		do_reset();
		rdchk(a_m0, tmc_pkg::MODE_RST);
		rdchk(tmc_pkg::ADDR_COUNT_U0, 8'h00);
		results();
	end
endmodule // eight_bit_timer_mode_control_tb
